// ### verilog/swire_pkg.sv
// Purpose: Shared constants for the one-pin step code link.
// Assumes: 50 MHz clock on both ends.
// Notes: Times kept in ns with derived cycle counts.
package swire_pkg;
    // =====================================================
    // Clock
    localparam int CLK_PERIOD_NS = 20;
    // =====================================================
    // Frame layout
    localparam logic [7:0] DEVICE_ADDR = 8'h72; // Fixed device address
    localparam int ACK_REQ_POS = 7; // Acknowledge request bit
    localparam int SUB_HI_POS = 6; // Sub-address high bit
    localparam int SUB_LO_POS = 5; // Sub-address low bit
    localparam int STEP_MSB = 4; // Step code top bit
    localparam int STEP_W = 5; // Step code width
    localparam logic [4:0] STEP_RESET = 5'h1F; // Full scale at reset
    localparam int BYTE_W = 8; // Bits per byte
    // =====================================================
    // Timing
    localparam int START_TIME_NS = 2000; // Least start high time
    localparam int STREAM_END_TIME_NS = 2000; // Least end-of-stream time
    localparam int ACK_DELAY_TIME_NS = 2000; // Delay before pull-down
    localparam int ACK_PULSE_TIME_NS = 512000; // Longest ack pulse
    localparam int START_CYC =
        (START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STREAM_END_CYC =
        (STREAM_END_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_DELAY_CYC = ACK_DELAY_TIME_NS / CLK_PERIOD_NS;
    localparam int ACK_PULSE_CYC = ACK_PULSE_TIME_NS / CLK_PERIOD_NS;
    // Slowest bit: 1/1.7 kbit/s, about 588 us
    localparam int SLOW_BIT_NS = 588236;
    localparam int SLOW_BIT_CYC = SLOW_BIT_NS / CLK_PERIOD_NS;
    localparam int CNT_W = $clog2(SLOW_BIT_CYC + 1) + 1;
    // Low held longer than this ends a byte
    localparam int BYTE_GAP_CYC = STREAM_END_CYC;
endpackage

// ### verilog/swire_if.sv
// Purpose: Open-drain one-pin link between host and receiver.
// Assumes: External pull-up holds the wire high when released.
// Notes: Wire resolves low if either end enables its driver with a low drive value.
`timescale 1ns/1ps
interface swire_if;
    logic host_o; // Host drive value
    logic host_oe; // Host drive enable
    logic dev_o; // Device drive value
    logic dev_oe; // Device drive enable
    logic line; // Resolved wire level
    // Pull-up wins unless someone drives low
    assign line = !((host_oe && !host_o) || (dev_oe && !dev_o));
    modport host (output host_o, output host_oe, input line);
    modport device (output dev_o, output dev_oe, input line);
endinterface

// ### verilog/swire_host.sv
// Purpose: Master end: sends address and data bytes, checks ack.
// Assumes: Open-drain drive with the interface pull-up.
// Notes: Bit period set by parameter; 1 = low 1/3, high 2/3.
`timescale 1ns/1ps
module swire_host
    import swire_pkg::*;
#(
    parameter int BIT_CYC = 300, // Bit period in cycles
    parameter int ACK_PULSE = ACK_PULSE_CYC // Wait for ack end
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic send_i, // Start a frame
    input wire logic [4:0] step_i, // Step code to send
    input wire logic ack_req_i, // Ask for acknowledge
    output logic busy_o, // Frame in progress
    output logic done_o, // Frame finished pulse
    output logic acked_o, // Ack seen on last ack-requested frame
    swire_if.host bus
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_START = 3'b001, H_LOW = 3'b011,
        H_HIGH = 3'b010, H_EOS = 3'b110, H_ACKW = 3'b111,
        H_ACKS = 3'b101
    } hstate_t;
    hstate_t state;
    logic [15:0] shreg; // Frame bits, MSB first
    logic [4:0] bitn; // Bits left
    logic [31:0] cnt; // Phase timer
    logic line_m, line_s; // Synchroniser
    logic want_ack;
    localparam int THIRD = BIT_CYC / 3;
    // =====================================================
    // Line synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_m <= 1'b1;
            line_s <= 1'b1;
        end else begin
            line_m <= bus.line;
            line_s <= line_m;
        end
    end
    // =====================================================
    // Frame sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= H_IDLE;
            shreg <= 16'h0000;
            bitn <= 5'h00;
            cnt <= 32'h0000_0000;
            bus.host_o <= 1'b1;
            want_ack <= 1'b0;
            acked_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state)
                H_IDLE: begin
                    bus.host_o <= 1'b1;
                    if (send_i) begin
                        // R1 R15: address then packed data byte
                        shreg <= {DEVICE_ADDR, ack_req_i, 2'b00, step_i};
                        want_ack <= ack_req_i; // [R4]
                        bitn <= 5'd16;
                        cnt <= 32'h0000_0000;
                        state <= H_START;
                    end
                end
                H_START: begin
                    // Hold high before each byte [R6]
                    cnt <= cnt + 32'd1;
                    if (cnt >= 32'(START_CYC)) begin
                        cnt <= 32'h0000_0000;
                        bus.host_o <= 1'b0;
                        state <= H_LOW;
                    end
                end
                H_LOW: begin
                    cnt <= cnt + 32'd1;
                    // Long phase twice the short one [R10]
                    if (cnt >= 32'(shreg[15] ? THIRD : 2 * THIRD)) begin
                        bus.host_o <= 1'b1;
                        state <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    cnt <= cnt + 32'd1;
                    if (cnt >= 32'(3 * THIRD)) begin
                        cnt <= 32'h0000_0000;
                        shreg <= {shreg[14:0], 1'b0}; // [R5]
                        bitn <= bitn - 5'd1;
                        if (bitn == 5'd9 || bitn == 5'd1) begin
                            bus.host_o <= 1'b0; // End of stream low
                            state <= H_EOS;
                        end else begin
                            bus.host_o <= 1'b0;
                            state <= H_LOW;
                        end
                    end
                end
                H_EOS: begin
                    // Low end-of-stream [R8]
                    cnt <= cnt + 32'd1;
                    if (cnt >= 32'(STREAM_END_CYC)) begin
                        cnt <= 32'h0000_0000;
                        if (bitn != 5'd0) begin
                            bus.host_o <= 1'b1;
                            state <= H_START;
                        end else if (want_ack) begin
                            state <= H_ACKW;
                        end else begin
                            bus.host_o <= 1'b1;
                            done_o <= 1'b1;
                            state <= H_IDLE;
                        end
                    end
                end
                H_ACKW: begin
                    // Keep low through the ack delay [R12]
                    cnt <= cnt + 32'd1;
                    if (cnt >= 32'(ACK_DELAY_CYC + 4)) begin
                        cnt <= 32'h0000_0000;
                        bus.host_o <= 1'b1;
                        state <= H_ACKS;
                    end
                end
                H_ACKS: begin
                    cnt <= cnt + 32'd1;
                    if (cnt == 32'd4) begin
                        acked_o <= !line_s; // [R13]
                    end
                    // Wait until pulse ends before reuse [R14]
                    if (cnt > 32'd4 && (line_s || cnt >= 32'(ACK_PULSE))) begin
                        done_o <= 1'b1;
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end
    // Open drain: drive only lows [R4]
    assign bus.host_oe = !bus.host_o;
    assign busy_o = (state != H_IDLE);
endmodule

// ### verilog/swire_device.sv
// Purpose: Receiver end: decodes frames, stores step, acknowledges.
// Assumes: Host keeps the phase ratio of at least two.
// Notes: Rate independent; only ratio of low to high counts.
//
// Behaviour
// R1: Data byte: ack request, sub-address, step
// R2: Ack only on request, address match, 16 bits
// R3: Ack is open-drain low pull-down
// R4: Master requests ack only if open drain
// R5: Bytes sent most significant bit first
// R6: Master holds high 2us before byte
// R7: Already-high line needs no start
// R8: Master ends each byte with 2us end
// R9: Bit timed falling edge to falling edge
// R10: Longer high means one, else zero
// R11: Pull-down after delay, at most 512us
// R12: Master holds line low during delay
// R13: Master releases, reads low as ack
// R14: Master waits for ack pulse end
// R15: First byte is fixed address 72 hex
// R16: Step register resets to all ones
// R17: Works from 1.7 to 160 kbit/s
// R18: Update step only on good frame
// R19: Phase counters cover slowest bit rate
`timescale 1ns/1ps
module swire_device
    import swire_pkg::*;
#(
    parameter int ACK_PULSE = ACK_PULSE_CYC // Ack pulse length
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [STEP_W-1:0] step_o, // Stored step code
    output logic frame_ok_o, // Good frame pulse
    output logic ack_busy_o, // Pull-down active
    swire_if.device bus
);
    typedef enum logic [1:0] {
        D_IDLE = 2'b00, D_LOW = 2'b01, D_HIGH = 2'b11, D_ACK = 2'b10
    } dstate_t;
    dstate_t state;
    logic line_m, line_s, line_d; // Sync and edge history
    logic fall; // Falling edge strobe
    logic [CNT_W-1:0] t_low, t_high; // Phase counters [R19]
    logic [15:0] bits; // Received bits
    logic [4:0] nbits; // Bit count this frame
    logic [3:0] inbyte; // Bits in current byte
    logic bad; // Framing error seen
    logic [31:0] ack_cnt; // Ack delay and pulse timer
    logic ack_phase; // 0 delay, 1 pulse
    logic [15:0] nxt_bits;
    // =====================================================
    // Pin synchroniser; first flop read by second only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_m <= 1'b1;
            line_s <= 1'b1;
            line_d <= 1'b1;
        end else begin
            line_m <= bus.line;
            line_s <= line_m;
            line_d <= line_s;
        end
    end
    assign fall = line_d && !line_s; // [R9]
    // Bit decided by ratio only [R10] [R17]
    assign nxt_bits = {bits[14:0], (t_high > t_low)}; // [R5]
    // =====================================================
    // Receiver and ack sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= D_IDLE;
            t_low <= '0;
            t_high <= '0;
            bits <= 16'h0000;
            nbits <= 5'h00;
            inbyte <= 4'h0;
            bad <= 1'b0;
            ack_cnt <= 32'h0000_0000;
            ack_phase <= 1'b0;
            bus.dev_o <= 1'b1;
            step_o <= STEP_RESET; // [R16]
            frame_ok_o <= 1'b0;
        end else begin
            frame_ok_o <= 1'b0;
            case (state)
                D_IDLE: begin
                    // Any fall from high starts a bit [R7]
                    if (fall) begin
                        t_low <= '0;
                        t_high <= '0;
                        state <= D_LOW;
                    end
                end
                D_LOW: begin
                    if (line_s) begin
                        state <= D_HIGH;
                    end else if (t_low < CNT_W'(SLOW_BIT_CYC)) begin
                        t_low <= t_low + 1'b1;
                    end else if (inbyte == 4'd8 || inbyte == 4'd0) begin
                        // Long low: end of stream after a byte
                        state <= D_IDLE;
                    end
                    // Sync and edge flops hide the first cycles of the
                    // low, so the close fires a few counts early [R8]
                    if (!line_s && t_low == CNT_W'(STREAM_END_CYC - 4)
                        && inbyte == 4'd8) begin
                        // Byte closed; the start high comes next
                        inbyte <= 4'd0;
                        state <= D_IDLE;
                        if (nbits == 5'd16) begin
                            // Check frame [R2] [R15] [R1]
                            if (!bad && bits[15:8] == DEVICE_ADDR
                                && bits[SUB_HI_POS:SUB_LO_POS] == 2'b00) begin
                                step_o <= bits[STEP_MSB:0]; // [R18]
                                frame_ok_o <= 1'b1;
                                if (bits[ACK_REQ_POS]) begin
                                    ack_cnt <= 32'h0000_0000;
                                    ack_phase <= 1'b0;
                                    state <= D_ACK;
                                end
                            end
                            nbits <= 5'd0;
                            bad <= 1'b0;
                        end
                    end
                end
                D_HIGH: begin
                    if (fall) begin
                        // Bit complete at next fall [R9]
                        bits <= nxt_bits;
                        nbits <= (nbits < 5'd16) ? nbits + 5'd1 : nbits;
                        if (inbyte == 4'd8) bad <= 1'b1;
                        inbyte <= inbyte + 4'd1;
                        t_low <= '0;
                        t_high <= '0;
                        state <= D_LOW;
                    end else if (t_high < CNT_W'(SLOW_BIT_CYC)) begin
                        t_high <= t_high + 1'b1;
                    end else begin
                        // Long high: start condition, restart
                        if (inbyte != 4'd0) begin
                            bits <= nxt_bits;
                            nbits <= nbits + 5'd1;
                        end
                        inbyte <= 4'd0;
                        nbits <= 5'd0;
                        bad <= 1'b0;
                        state <= D_IDLE;
                    end
                end
                D_ACK: begin
                    ack_cnt <= ack_cnt + 32'd1;
                    if (!ack_phase && ack_cnt >= 32'(ACK_DELAY_CYC)) begin
                        ack_cnt <= 32'h0000_0000;
                        ack_phase <= 1'b1;
                        bus.dev_o <= 1'b0; // [R11] [R3]
                    end else if (ack_phase
                                 && ack_cnt >= 32'(ACK_PULSE - 1)) begin
                        bus.dev_o <= 1'b1; // Release [R11]
                        ack_phase <= 1'b0;
                        state <= D_IDLE;
                    end
                end
                default: state <= D_IDLE;
            endcase
        end
    end
    // Drive only while pulling low [R3]
    assign bus.dev_oe = !bus.dev_o;
    assign ack_busy_o = !bus.dev_o;
endmodule

// ### sim/swire_monitor.sv
// Purpose: Checks the one-pin link between host and receiver.
// Assumes: Both ends share clk_i and rst_i.
// Notes: Watches the interface signals only.
`timescale 1ns/1ps
module swire_monitor
    import swire_pkg::*;
#(
    parameter int ACK_PULSE = ACK_PULSE_CYC // Ack pulse length
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic line
);
    // =====================================================
    // Helper counters
    int low_cnt; // Run of low samples
    int hi_cnt; // Run of high samples
    int ack_cnt; // Run of pull-down samples
    logic ack_seen; // Ack happened since last fall
    // Phase length counters; a run restarts on each level change
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt <= 0;
            hi_cnt <= 0;
        end else if (line) begin
            low_cnt <= 0;
            hi_cnt <= hi_cnt + 1;
        end else begin
            low_cnt <= low_cnt + 1;
            hi_cnt <= 0;
        end
    end
    // Pull-down length and ack memory
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_cnt <= 0;
            ack_seen <= 1'b0;
        end else begin
            ack_cnt <= dev_oe ? ack_cnt + 1 : 0;
            if (dev_oe) begin
                ack_seen <= 1'b1;
            end else if (!line && hi_cnt != 0) begin
                ack_seen <= 1'b0;
            end
        end
    end
    // =====================================================
    // Properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_dev_open_drain: assert property (dev_oe |-> !dev_o)
        else $error("device drives the wire high");
    chk_host_open_drain: assert property (host_oe |-> !host_o)
        else $error("host drives the wire high");
    chk_line_pulled: assert property (dev_oe |-> !line)
        else $error("pull-down does not reach the wire");
    chk_ack_max_len: assert property (ack_cnt <= ACK_PULSE)
        else $error("ack pulse too long");
    chk_ack_full_len: assert property (
        $fell(dev_oe) |-> ack_cnt >= ACK_PULSE - 2)
        else $error("ack pulse cut short");
    chk_ack_delay_low: assert property (
        $rose(dev_oe) |-> low_cnt >= ACK_DELAY_CYC)
        else $error("ack began before the delay ran out");
    chk_host_release_ack: assert property (
        $rose(dev_oe) |-> ##[0:8] !host_oe)
        else $error("host did not release during ack");
    chk_host_idle_ack: assert property ($fell(dev_oe) |-> !host_oe)
        else $error("host drives the wire as ack ends");
    chk_start_after_ack: assert property (
        (ack_seen && !line && hi_cnt != 0) |-> hi_cnt >= START_CYC)
        else $error("new byte began without a start time");
endmodule

// ### sim/single_wire_fb_step_receiver_test.sv
// Purpose: Runs frames over both link ends and a faulty host path.
// Assumes: Ack pulse shortened to AP cycles.
// Notes: Second link is driven by the bench to send good and bad frames.
`timescale 1ns/1ps
module single_wire_fb_step_receiver_test
    import swire_pkg::*;
;
    // =====================================================
    // Signals
    localparam int AP = 200; // Short ack keeps the run brief
    localparam int BC = 330; // Bit period, about 152 kbit/s
    logic clk_i = 1'b0;
    logic rst_i = 1'b1; // Held from time zero
    logic send_i = 1'b0;
    logic [4:0] step_i = 5'h00;
    logic ack_req_i = 1'b0;
    logic busy, acked, frame_ok, ack_busy, frame_ok2, ack_busy2, done;
    logic ack_exp = 1'b0; // Ack flag stands until the next ack check
    logic [STEP_W-1:0] step, step2, exp2;
    logic prev_line = 1'b1;
    logic pa = 1'b0;
    logic pa2 = 1'b0;
    logic [31:0] hist; // Decoded wire bits, newest at bit 0
    int nfall, lo_c, hi_c, ok_cnt, ok2_cnt, ack_cnt, ack2_cnt, done_cnt;
    int err_count, checks;
    swire_if link();
    swire_if bad_if();
    always #10 clk_i = ~clk_i;
    swire_host #(.BIT_CYC(BC), .ACK_PULSE(AP)) swire_host_inst (
        .clk_i(clk_i), .rst_i(rst_i), .send_i(send_i), .step_i(step_i),
        .ack_req_i(ack_req_i), .busy_o(busy), .done_o(done),
        .acked_o(acked), .bus(link.host));
    swire_device #(.ACK_PULSE(AP)) swire_device_inst (
        .clk_i(clk_i), .rst_i(rst_i), .step_o(step), .frame_ok_o(frame_ok),
        .ack_busy_o(ack_busy), .bus(link.device));
    swire_device #(.ACK_PULSE(AP)) swire_device_inst2 (
        .clk_i(clk_i), .rst_i(rst_i), .step_o(step2),
        .frame_ok_o(frame_ok2), .ack_busy_o(ack_busy2),
        .bus(bad_if.device));
    swire_monitor #(.ACK_PULSE(AP)) swire_monitor_inst (
        .clk_i(clk_i), .rst_i(rst_i), .host_o(link.host_o),
        .host_oe(link.host_oe), .dev_o(link.dev_o), .dev_oe(link.dev_oe),
        .line(link.line));
    // Bench bit decoder on the wire: one bit per fall-to-fall span
    always @(posedge clk_i) begin
        if (prev_line && !link.line) begin
            if (nfall != 0) hist <= {hist[30:0], hi_c > lo_c};
            nfall <= nfall + 1;
            lo_c <= 0;
            hi_c <= 0;
        end else if (link.line) hi_c <= hi_c + 1;
        else lo_c <= lo_c + 1;
        prev_line <= link.line;
        ok_cnt <= ok_cnt + frame_ok;
        done_cnt <= done_cnt + done;
        ok2_cnt <= ok2_cnt + frame_ok2;
        ack_cnt <= ack_cnt + (ack_busy && !pa);
        ack2_cnt <= ack2_cnt + (ack_busy2 && !pa2);
        pa <= ack_busy;
        pa2 <= ack_busy2;
    end
    // =====================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One host frame; poke retries send while busy, which must be ignored
    task automatic send(input logic [4:0] s, input logic r, input bit poke);
        int n0, k0, a0, d0, k;
        n0 = nfall;
        d0 = done_cnt;
        k0 = ok_cnt;
        a0 = ack_cnt;
        @(negedge clk_i);
        step_i = s;
        ack_req_i = r;
        send_i = 1'b1;
        @(negedge clk_i);
        send_i = 1'b0;
        if (poke) begin
            repeat (5) @(negedge clk_i);
            step_i = ~s;
            send_i = 1'b1;
            @(negedge clk_i);
            send_i = 1'b0;
        end
        k = 0;
        while ((busy !== 1'b0 || ok_cnt == k0) && k < 20000) begin
            @(negedge clk_i);
            k++;
        end
        // Let the done pulse reach its counter
        repeat (2) @(negedge clk_i);
        if (r) ack_exp = 1'b1;
        chk(step, s);
        chk(acked, ack_exp);
        chk(done_cnt - d0, 1);
        chk(ok_cnt - k0, 1);
        chk(ack_cnt - a0, r);
        chk(nfall - n0, 18);
        chk(hist[16:9], DEVICE_ADDR);
        chk(hist[7:0], {r, 2'b00, s});
    endtask
    // Bench-made frame on the second link, any address or data
    task automatic bang(input logic [7:0] a, input logic [7:0] d, int bc);
        logic [15:0] w;
        logic good;
        int k0, a0, k;
        w = {a, d};
        good = (a == DEVICE_ADDR) && (d[6:5] == 2'b00);
        k0 = ok2_cnt;
        a0 = ack2_cnt;
        for (int i = 15; i >= 0; i--) begin
            if (i == 7) begin
                bad_if.host_oe = 1'b1; // End of address byte
                repeat (STREAM_END_CYC + 10) @(negedge clk_i);
                bad_if.host_oe = 1'b0; // Start before data byte
                repeat (START_CYC + 10) @(negedge clk_i);
            end
            bad_if.host_oe = 1'b1;
            repeat (w[i] ? bc / 3 : 2 * bc / 3) @(negedge clk_i);
            bad_if.host_oe = 1'b0;
            repeat (w[i] ? 2 * bc / 3 : bc / 3) @(negedge clk_i);
        end
        // Low through end of stream and the ack delay
        bad_if.host_oe = 1'b1;
        repeat (STREAM_END_CYC + ACK_DELAY_CYC + 6) @(negedge clk_i);
        bad_if.host_oe = 1'b0;
        repeat (4) @(negedge clk_i);
        chk(bad_if.line, !(good && d[7]));
        k = 0;
        while (bad_if.line !== 1'b1 && k < AP + 50) begin
            @(negedge clk_i);
            k++;
        end
        if (good) exp2 = d[4:0];
        repeat (START_CYC + 10) @(negedge clk_i);
        chk(step2, exp2);
        chk(ok2_cnt - k0, good);
        chk(ack2_cnt - a0, good && d[7]);
    endtask
    // =====================================================
    // Main sequence; both links run side by side
    initial begin
        bad_if.host_o = 1'b0;
        bad_if.host_oe = 1'b0;
        exp2 = STEP_RESET;
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (5) @(negedge clk_i);
        chk(step, STEP_RESET);
        chk(step2, STEP_RESET);
        chk(link.line, 1'b1);
        fork
            begin
                send(5'h00, 1'b1, 1'b0);
                send(5'h1F, 1'b0, 1'b1);
                send(5'h15, 1'b1, 1'b0);
                send(5'h0A, 1'b0, 1'b0);
            end
            begin
                bang(8'h72, 8'h83, 1200);
                bang(8'h73, 8'h81, BC);
                bang(8'h72, 8'hA5, BC);
                bang(8'h72, 8'hC2, BC);
                bang(8'h72, 8'h1C, BC);
            end
        join
        wrap_up();
    end
    // Watchdog: about twice the expected run
    initial begin
        #2_000_000;
        err_count++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        wrap_up();
    end
endmodule
